// file: hdl/pdr_pkg.sv
// Shared constants, types and helpers for the divider programming link
package pdr_pkg;

	// Serial frame layout
	localparam int FRAME_BITS = 25;
	localparam int DATA_BITS = 16;
	localparam int RADDR_LSB = 16;
	localparam int RADDR_MSB = 20;
	localparam int DEVA_LSB = 21;
	localparam int DEVA_MSB = 24;
	localparam logic [4:0] FRAME_BITS_CNT = 5'h19;

	// Device address code, value is arbitrary
	localparam logic [3:0] DEV_ADDR = 4'hA;

	// Divider register addresses inside the frame
	localparam logic [4:0] RA_REF = 5'h00;
	localparam logic [4:0] RA_FB_LO = 5'h01;
	localparam logic [4:0] RA_FB_HI = 5'h02;

	// Divider fields
	localparam int REF_BITS = 11;
	localparam int FB_BITS = 18;
	localparam int FB_HI_BITS = 2;
	localparam int PDIV_LSB = 11;
	localparam int PDIV_MSB = 12;

	// Divider register reset values
	localparam logic [15:0] REF_REG_RST = 16'h0001;
	localparam logic [15:0] FB_LO_RST = 16'h0400;
	localparam logic [15:0] FB_HI_RST = 16'h0000;

	// Post-divider ratios
	typedef enum logic [1:0] {
		PDIV_1 = 2'b00,
		PDIV_2 = 2'b01,
		PDIV_4 = 2'b10,
		PDIV_8 = 2'b11
	} pdr_pdiv_t;

	// Host register offsets and status bits
	localparam logic [7:0] OFS_FRAME = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_HALF = 8'h08;
	localparam int STAT_BUSY = 0;
	localparam int STAT_OVR = 1;
	localparam int STAT_RANGE = 2;
	localparam logic [7:0] HALF_RST = 8'h04;

	// Link timing, nanoseconds
	localparam int CLK_NS = 10;
	localparam int T_PERIOD_NS = 25;
	localparam int T_HIGH_NS = 10;
	localparam int T_ELCH_NS = 10;
	localparam int T_WIDTH_NS = 10;
	localparam int T_EFEH_NS = 20;
	// Receiver samples through two flops and needs three cycles per level
	localparam int SYNC_CYC = 3;

	function automatic int pdr_cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < SYNC_CYC) ? SYNC_CYC : c;
	endfunction

	localparam int HALF_PER = pdr_cyc((T_PERIOD_NS + 1) / 2);
	localparam int HALF_HI = pdr_cyc(T_HIGH_NS);
	localparam logic [7:0] HALF_MIN =
		8'((HALF_PER > HALF_HI) ? HALF_PER : HALF_HI);
	localparam logic [7:0] LEAD_CYC = 8'(pdr_cyc(T_ELCH_NS));
	localparam logic [7:0] TAIL_CYC = 8'(pdr_cyc(T_EFEH_NS));
	localparam logic [7:0] WIDTH_CYC = 8'(pdr_cyc(T_WIDTH_NS));

	// Host sequencer states
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_LEAD = 3'b001,
		H_LOW = 3'b010,
		H_HIGH = 3'b011,
		H_TAIL = 3'b100,
		H_STROBE = 3'b101
	} pdr_hstate_t;

	function automatic logic pdr_rise(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction

endpackage

// file: hdl/pdr_serial_if.sv
// Three-wire serial write link between host and divider device
`timescale 1ns/100ps
interface pdr_serial_if;
	logic sclk;
	logic sdata;
	logic latch_strobe;

	modport host (
		output sclk,
		output sdata,
		output latch_strobe
	);

	modport dev (
		input sclk,
		input sdata,
		input latch_strobe
	);
endinterface

// file: hdl/pdr_shift_rx.sv
// Pin synchroniser and frame shifter for the serial write link
`timescale 1ns/100ps
module pdr_shift_rx import pdr_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Serial pins
	input wire logic sclk_pin,
	input wire logic sdata_pin,
	input wire logic strobe_pin,
	// Received frame
	output logic [FRAME_BITS-1:0] frame_word,
	output logic frame_ok,
	output logic frame_bad
);

	logic [2:0] s1_ff;
	logic [2:0] s2_ff;
	logic [2:0] s3_ff;
	logic [FRAME_BITS-1:0] shift_ff;
	logic [4:0] cnt_ff;
	logic [FRAME_BITS-1:0] word_ff;
	logic ok_ff;
	logic bad_ff;

	wire sclk_rise = pdr_rise(s2_ff[0], s3_ff[0]);
	wire strobe_rise = pdr_rise(s2_ff[2], s3_ff[2]);
	wire shift_en = sclk_rise & ~s2_ff[2];
	wire cnt_full = (cnt_ff == 5'h1F);
	wire len_ok = (cnt_ff == FRAME_BITS_CNT);

	// s1 feeds only s2; edges are found on s2 against s3
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Idle levels, so no false edge follows reset
			s1_ff <= 3'h4;
			s2_ff <= 3'h4;
			s3_ff <= 3'h4;
		end else begin
			s1_ff <= {strobe_pin, sdata_pin, sclk_pin};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_ff <= '0;
			cnt_ff <= 5'h00;
		end else if (s2_ff[2]) begin
			cnt_ff <= 5'h00;
		end else if (shift_en) begin
			shift_ff <= {shift_ff[FRAME_BITS-2:0], s2_ff[1]};
			cnt_ff <= cnt_full ? cnt_ff : cnt_ff + 5'h01;
		end
	end

	// Strobe rise hands over the frame, wrong lengths are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			word_ff <= '0;
			ok_ff <= 1'b0;
			bad_ff <= 1'b0;
		end else begin
			ok_ff <= strobe_rise & len_ok;
			bad_ff <= strobe_rise & ~len_ok;
			if (strobe_rise) begin
				word_ff <= shift_ff;
			end
		end
	end

	assign frame_word = word_ff;
	assign frame_ok = ok_ff;
	assign frame_bad = bad_ff;

endmodule

// file: hdl/pdr_device.sv
// Divider register bank and counter chain of the synthesizer device
// How it works
// - Frames are 25 bits: address, data
// - Three divider registers: reference, feedback pair
// - Reference clock divided by 11-bit count
// - Upper register bits 1:0 are count MSBs
// - Lower register supplies feedback count LSBs
// - Post-divider ratios 1, 2, 4, 8 only
// - Host keeps VCO within 2.8-6.0 GHz; host logic does not check the VCO
// - Host sets comparison rate from step size; host logic sends the count software writes
// - Feedback count times comparison gives VCO
// - Counts loaded only over the serial link
// - Accept frame only on matching device address
// - Host keeps reference count 1 to 2047
`timescale 1ns/100ps
module pdr_device import pdr_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Serial link
	pdr_serial_if.dev link,
	// Synthesizer clock pins
	input wire logic ref_clk_pin,
	input wire logic vco_clk_pin,
	// Divider settings
	output logic [REF_BITS-1:0] ref_count,
	output logic [FB_BITS-1:0] fb_count,
	output pdr_pdiv_t post_div,
	// Loop outputs
	output logic comp_tick,
	output logic fb_tick,
	output logic pd_up,
	output logic pd_dn,
	output logic lo_out,
	// Frame status
	output logic frame_taken,
	output logic frame_dropped
);

	logic [FRAME_BITS-1:0] frame_word;
	logic frame_ok;
	logic frame_bad;
	logic [15:0] ref_reg_ff;
	logic [15:0] fb_lo_reg_ff;
	logic [15:0] fb_hi_reg_ff;
	logic taken_ff;
	logic dropped_ff;
	logic [1:0] c1_ff;
	logic [1:0] c2_ff;
	logic [1:0] c3_ff;
	logic [FB_BITS-1:0] ref_cnt_ff;
	logic [FB_BITS-1:0] fb_cnt_ff;
	logic comp_ff;
	logic fbt_ff;
	logic up_ff;
	logic dn_ff;
	logic [2:0] post_cnt_ff;
	logic lo_ff;
	logic lo_sel;

	// Counter step: wraps to zero when the limit is reached
	function automatic logic [FB_BITS-1:0] pdr_step(
		input logic [FB_BITS-1:0] cnt,
		input logic [FB_BITS-1:0] lim
	);
		logic [FB_BITS-1:0] inc;
		inc = cnt + 18'h00001;
		return (inc >= lim) ? 18'h00000 : inc;
	endfunction

	pdr_shift_rx i_pdr_shift_rx (
		.pclk(pclk),
		.presetn(presetn),
		.sclk_pin(link.sclk),
		.sdata_pin(link.sdata),
		.strobe_pin(link.latch_strobe),
		.frame_word(frame_word),
		.frame_ok(frame_ok),
		.frame_bad(frame_bad)
	);

	// Frame decode
	wire [3:0] f_dev = frame_word[DEVA_MSB:DEVA_LSB];
	wire [4:0] f_addr = frame_word[RADDR_MSB:RADDR_LSB];
	wire [15:0] f_data = frame_word[DATA_BITS-1:0];
	wire dev_hit = frame_ok & (f_dev == DEV_ADDR);
	wire wr_ref = dev_hit & (f_addr == RA_REF);
	wire wr_fb_lo = dev_hit & (f_addr == RA_FB_LO);
	wire wr_fb_hi = dev_hit & (f_addr == RA_FB_HI);
	wire wr_any = wr_ref | wr_fb_lo | wr_fb_hi;

	// Only the serial link ever writes these
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_reg_ff <= REF_REG_RST;
			fb_lo_reg_ff <= FB_LO_RST;
			fb_hi_reg_ff <= FB_HI_RST;
		end else begin
			if (wr_ref) begin
				ref_reg_ff <= f_data;
			end
			if (wr_fb_lo) begin
				fb_lo_reg_ff <= f_data;
			end
			if (wr_fb_hi) begin
				fb_hi_reg_ff <= f_data;
			end
		end
	end

	// Anything not stored is reported as dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			taken_ff <= 1'b0;
			dropped_ff <= 1'b0;
		end else begin
			taken_ff <= wr_any;
			dropped_ff <= frame_bad | (frame_ok & ~wr_any);
		end
	end

	assign ref_count = ref_reg_ff[REF_BITS-1:0];
	assign fb_count = {fb_hi_reg_ff[FB_HI_BITS-1:0],
		fb_lo_reg_ff};
	assign post_div = pdr_pdiv_t'(ref_reg_ff[PDIV_MSB:PDIV_LSB]);
	assign frame_taken = taken_ff;
	assign frame_dropped = dropped_ff;

	// Clock pins sampled through two flops, edges on the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c1_ff <= 2'h0;
			c2_ff <= 2'h0;
			c3_ff <= 2'h0;
		end else begin
			c1_ff <= {vco_clk_pin, ref_clk_pin};
			c2_ff <= c1_ff;
			c3_ff <= c2_ff;
		end
	end

	wire ref_rise = pdr_rise(c2_ff[0], c3_ff[0]);
	wire vco_rise = pdr_rise(c2_ff[1], c3_ff[1]);

	// A zero count behaves as one, wrapping on every step
	wire [FB_BITS-1:0] ref_lim = (ref_count == '0) ? 18'h00001 :
		{7'h00, ref_count};
	wire [FB_BITS-1:0] fb_lim = (fb_count == '0) ? 18'h00001 : fb_count;
	wire [FB_BITS-1:0] ref_nxt = pdr_step(ref_cnt_ff, ref_lim);
	wire [FB_BITS-1:0] fb_nxt = pdr_step(fb_cnt_ff, fb_lim);
	wire nxt_comp = ref_rise & (ref_nxt == '0);
	wire nxt_fbt = vco_rise & (fb_nxt == '0);

	// New counts apply from the next counter step, no restart needed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_cnt_ff <= '0;
			fb_cnt_ff <= '0;
			comp_ff <= 1'b0;
			fbt_ff <= 1'b0;
		end else begin
			if (ref_rise) begin
				ref_cnt_ff <= ref_nxt;
			end
			if (vco_rise) begin
				fb_cnt_ff <= fb_nxt;
			end
			comp_ff <= nxt_comp;
			fbt_ff <= nxt_fbt;
		end
	end

	assign comp_tick = comp_ff;
	assign fb_tick = fbt_ff;

	// Phase detector: lead sets a flag, both flags cancel
	wire up_set = up_ff | comp_ff;
	wire dn_set = dn_ff | fbt_ff;
	wire both = up_set & dn_set;
	wire nxt_up = up_set & ~both;
	wire nxt_dn = dn_set & ~both;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_ff <= 1'b0;
			dn_ff <= 1'b0;
		end else begin
			up_ff <= nxt_up;
			dn_ff <= nxt_dn;
		end
	end

	assign pd_up = up_ff;
	assign pd_dn = dn_ff;

	// Post-divider; ratio 1 follows the sampled VCO pin
	always_comb begin
		case (post_div)
			PDIV_1: lo_sel = c2_ff[1];
			PDIV_2: lo_sel = post_cnt_ff[0];
			PDIV_4: lo_sel = post_cnt_ff[1];
			PDIV_8: lo_sel = post_cnt_ff[2];
			default: lo_sel = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			post_cnt_ff <= 3'h0;
			lo_ff <= 1'b0;
		end else begin
			if (vco_rise) begin
				post_cnt_ff <= post_cnt_ff + 3'h1;
			end
			lo_ff <= lo_sel;
		end
	end

	assign lo_out = lo_ff;

endmodule

// file: hdl/pdr_host.sv
// APB-controlled host that writes divider frames over the serial link
`timescale 1ns/100ps
module pdr_host import pdr_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial link
	pdr_serial_if.host link
);

	pdr_hstate_t state_ff;
	pdr_hstate_t nxt_state;
	logic [20:0] frame_ff;
	logic [7:0] half_ff;
	logic ovr_ff;
	logic range_ff;
	logic [7:0] tmr_ff;
	logic [7:0] nxt_tmr;
	logic [4:0] bit_ff;
	logic [4:0] nxt_bit;
	logic [FRAME_BITS-1:0] sh_ff;
	logic [FRAME_BITS-1:0] nxt_sh;
	logic sclk_ff;
	logic nxt_sclk;
	logic sdata_ff;
	logic nxt_sdata;
	logic strobe_ff;
	logic nxt_strobe;

	// APB decode, zero wait states
	wire wr_en = psel & penable & pwrite;
	wire wr_frame = wr_en & (paddr == OFS_FRAME);
	wire wr_stat = wr_en & (paddr == OFS_STAT);
	wire wr_half = wr_en & (paddr == OFS_HALF);
	wire idle = (state_ff == H_IDLE);
	wire [4:0] w_addr = pwdata[RADDR_MSB:RADDR_LSB];
	wire ref_zero = (w_addr == RA_REF) & (pwdata[REF_BITS-1:0] == '0);
	wire start = wr_frame & idle & ~ref_zero;
	wire tmr_done = (tmr_ff == 8'h00);
	wire [7:0] half = (half_ff < HALF_MIN) ? HALF_MIN : half_ff;

	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = (paddr == OFS_FRAME) ? {11'h000, frame_ff} :
		(paddr == OFS_STAT) ? {29'h0, range_ff, ovr_ff, ~idle} :
		(paddr == OFS_HALF) ? {24'h000000, half_ff} : 32'h00000000;

	// Sticky errors: a new event wins over a write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_ff <= '0;
			half_ff <= HALF_RST;
			ovr_ff <= 1'b0;
			range_ff <= 1'b0;
		end else begin
			if (start) begin
				frame_ff <= pwdata[20:0];
			end
			if (wr_half) begin
				half_ff <= pwdata[7:0];
			end
			ovr_ff <= (wr_frame & ~idle) |
				(ovr_ff & ~(wr_stat & pwdata[STAT_OVR]));
			range_ff <= (wr_frame & idle & ref_zero) |
				(range_ff & ~(wr_stat & pwdata[STAT_RANGE]));
		end
	end

	// Frame sequencer; data changes on the falling clock edge
	always_comb begin
		nxt_state = state_ff;
		nxt_tmr = tmr_done ? tmr_ff : tmr_ff - 8'h01;
		nxt_bit = bit_ff;
		nxt_sh = sh_ff;
		nxt_sclk = sclk_ff;
		nxt_sdata = sdata_ff;
		nxt_strobe = strobe_ff;
		case (state_ff)
			H_IDLE: begin
				if (start) begin
					// Software computes counts and ratio
					nxt_sh = {DEV_ADDR, pwdata[20:0]};
					nxt_strobe = 1'b0;
					nxt_tmr = LEAD_CYC - 8'h01;
					nxt_state = H_LEAD;
				end
			end
			H_LEAD: begin
				if (tmr_done) begin
					nxt_sdata = sh_ff[FRAME_BITS-1];
					nxt_bit = 5'h00;
					nxt_tmr = half - 8'h01;
					nxt_state = H_LOW;
				end
			end
			H_LOW: begin
				if (tmr_done) begin
					nxt_sclk = 1'b1;
					nxt_tmr = half - 8'h01;
					nxt_state = H_HIGH;
				end
			end
			H_HIGH: begin
				if (tmr_done) begin
					nxt_sclk = 1'b0;
					if (bit_ff == FRAME_BITS_CNT - 5'h01) begin
						nxt_tmr = TAIL_CYC - 8'h01;
						nxt_state = H_TAIL;
					end else begin
						nxt_sh = {sh_ff[FRAME_BITS-2:0], 1'b0};
						nxt_sdata = sh_ff[FRAME_BITS-2];
						nxt_bit = bit_ff + 5'h01;
						nxt_tmr = half - 8'h01;
						nxt_state = H_LOW;
					end
				end
			end
			H_TAIL: begin
				if (tmr_done) begin
					nxt_strobe = 1'b1;
					nxt_tmr = WIDTH_CYC - 8'h01;
					nxt_state = H_STROBE;
				end
			end
			H_STROBE: begin
				if (tmr_done) begin
					nxt_state = H_IDLE;
				end
			end
			default: begin
				nxt_state = H_IDLE;
				nxt_strobe = 1'b1;
				nxt_sclk = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= H_IDLE;
			tmr_ff <= 8'h00;
			bit_ff <= 5'h00;
			sh_ff <= '0;
			sclk_ff <= 1'b0;
			sdata_ff <= 1'b0;
			strobe_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			tmr_ff <= nxt_tmr;
			bit_ff <= nxt_bit;
			sh_ff <= nxt_sh;
			sclk_ff <= nxt_sclk;
			sdata_ff <= nxt_sdata;
			strobe_ff <= nxt_strobe;
		end
	end

	assign link.sclk = sclk_ff;
	assign link.sdata = sdata_ff;
	assign link.latch_strobe = strobe_ff;

endmodule

// file: verif/pdr_link_properties.sv
// Checks on the serial link and the divider register outputs
`timescale 1ns/100ps
module pdr_link_props import pdr_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Serial link
	input wire logic sclk,
	input wire logic sdata,
	input wire logic latch_strobe,
	// Device results
	input wire logic [REF_BITS-1:0] ref_count,
	input wire logic [FB_BITS-1:0] fb_count,
	input wire pdr_pdiv_t post_div,
	input wire logic frame_taken,
	input wire logic frame_dropped,
	// Loop outputs
	input wire logic comp_tick,
	input wire logic fb_tick,
	input wire logic pd_up,
	input wire logic pd_dn
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Counts sclk rises inside a frame
	logic sclk_q_ff;
	logic sclk_rise;
	logic [4:0] bits_ff;
	logic [4:0] nxt_bits;
	// Shadow of the frame seen on the wire
	logic [FRAME_BITS-1:0] fr_ff;
	assign sclk_rise = sclk & ~sclk_q_ff;
	assign nxt_bits = latch_strobe ? 5'h00 : bits_ff + {4'h0, sclk_rise};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_q_ff <= 1'b0;
			bits_ff <= 5'h00;
			fr_ff <= '0;
		end else begin
			sclk_q_ff <= sclk;
			bits_ff <= nxt_bits;
			if (sclk_rise && !latch_strobe) begin
				fr_ff <= {fr_ff[FRAME_BITS-2:0], sdata};
			end
		end
	end

	sequence s_strobe_rise;
		$rose(latch_strobe);
	endsequence
	sequence s_strobe_held;
		latch_strobe [*3];
	endsequence
	sequence s_result;
		frame_taken || frame_dropped;
	endsequence
	sequence s_ref_lead;
		comp_tick && !fb_tick && !pd_dn;
	endsequence
	sequence s_fb_lead;
		fb_tick && !comp_tick && !pd_up;
	endsequence

	property p_frame_len;
		s_strobe_rise |-> bits_ff == FRAME_BITS_CNT;
	endproperty
	property p_strobe_hold;
		s_strobe_rise |-> s_strobe_held;
	endproperty
	property p_store_lat;
		s_strobe_rise |-> ##[2:6] s_result;
	endproperty
	property p_idle_clk;
		latch_strobe |-> !sclk;
	endproperty
	// Data holds steady while the clock stays high
	property p_data_hold;
		sclk && sclk_q_ff |-> $stable(sdata);
	endproperty
	property p_one_result;
		!(frame_taken && frame_dropped);
	endproperty
	property p_pulse_single;
		frame_taken |=> !frame_taken;
	endproperty
	property p_regs_hold;
		!frame_taken |-> $stable(ref_count) && $stable(fb_count)
			&& $stable(post_div);
	endproperty
	property p_dev_match;
		frame_taken |-> fr_ff[DEVA_MSB:DEVA_LSB] == DEV_ADDR;
	endproperty
	property p_addr_known;
		frame_taken |-> fr_ff[RADDR_MSB:RADDR_LSB] <= RA_FB_HI;
	endproperty
	property p_pd_up;
		s_ref_lead |=> pd_up;
	endproperty
	property p_pd_dn;
		s_fb_lead |=> pd_dn;
	endproperty
	property p_pd_excl;
		!(pd_up && pd_dn);
	endproperty

	a_frame_len: assert property (p_frame_len)
		else $error("frame bit count wrong");
	a_strobe_hold: assert property (p_strobe_hold)
		else $error("strobe high too short");
	a_store_lat: assert property (p_store_lat)
		else $error("no frame result after strobe");
	a_idle_clk: assert property (p_idle_clk)
		else $error("sclk high outside frame");
	a_data_hold: assert property (p_data_hold)
		else $error("sdata moved while sclk high");
	a_one_result: assert property (p_one_result)
		else $error("frame both taken and dropped");
	a_pulse_single: assert property (p_pulse_single)
		else $error("taken pulse longer than a cycle");
	a_regs_hold: assert property (p_regs_hold)
		else $error("divider changed without a frame");
	a_dev_match: assert property (p_dev_match)
		else $error("frame stored for another device code");
	a_addr_known: assert property (p_addr_known)
		else $error("frame stored for an unknown address");
	a_pd_up: assert property (p_pd_up)
		else $error("reference lead gave no up");
	a_pd_dn: assert property (p_pd_dn)
		else $error("feedback lead gave no down");
	a_pd_excl: assert property (p_pd_excl)
		else $error("up and down high together");
endmodule

// file: verif/tb_pll_divider_program_regs.sv
// Testbench joining host and device over the serial link
`timescale 1ns/100ps
module tb_pll_divider_program_regs import pdr_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] div_ff;
	logic [REF_BITS-1:0] ref_count;
	logic [FB_BITS-1:0] fb_count;
	pdr_pdiv_t post_div;
	logic comp_tick, fb_tick, pd_up, pd_dn, lo_out;
	logic frame_taken, frame_dropped;
	int failures, n_tests, cyc;
	wire [2:0] mon = {lo_out, fb_tick, comp_tick};
	// Pin periods in pclk: ref pin is div_ff[3], vco pin div_ff[2]
	localparam int REF_T = 16;
	localparam int VCO_T = 8;

	pdr_serial_if i_pdr_serial_if();
	pdr_host i_pdr_host(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(i_pdr_serial_if));
	pdr_device i_pdr_device(.pclk(pclk), .presetn(presetn),
		.link(i_pdr_serial_if), .ref_clk_pin(div_ff[3]),
		.vco_clk_pin(div_ff[2]), .ref_count(ref_count),
		.fb_count(fb_count), .post_div(post_div), .comp_tick(comp_tick),
		.fb_tick(fb_tick), .pd_up(pd_up), .pd_dn(pd_dn), .lo_out(lo_out),
		.frame_taken(frame_taken), .frame_dropped(frame_dropped));
	pdr_link_props i_pdr_link_props(.pclk(pclk), .presetn(presetn),
		.sclk(i_pdr_serial_if.sclk), .sdata(i_pdr_serial_if.sdata),
		.latch_strobe(i_pdr_serial_if.latch_strobe),
		.ref_count(ref_count), .fb_count(fb_count), .post_div(post_div),
		.frame_taken(frame_taken), .frame_dropped(frame_dropped),
		.comp_tick(comp_tick), .fb_tick(fb_tick), .pd_up(pd_up),
		.pd_dn(pd_dn));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Slow test clocks, each level lasts several pclk
	always @(posedge pclk) begin
		div_ff <= div_ff + 4'h1;
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			failures++;
			end_sim();
		end
	end

	task end_sim();
		$display("Checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Wait ends once pready reads high
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, e);
	endtask

	// Polls busy; rd keeps the last status word
	task idle();
		do begin
			apb(1'b0, OFS_STAT, 32'h0);
		end while (rd[STAT_BUSY] !== 1'b0);
	endtask

	// Cycles between the second and third rise of one output
	task per(input int k, input int exp, input string nm);
		int n, r;
		logic q;
		n = 0;
		r = 0;
		q = 1'b1;
		while (r < 3) begin
			@(negedge pclk);
			if (r == 2) begin
				n++;
			end
			if (mon[k] === 1'b1 && q !== 1'b1) begin
				r++;
			end
			q = mon[k];
		end
		chk(nm, n, exp);
	endtask

	task frame(input logic [4:0] a, input logic [15:0] d, input logic ok);
		apb(1'b1, OFS_FRAME, {11'h000, a, d});
		while (frame_taken !== 1'b1 && frame_dropped !== 1'b1) begin
			@(negedge pclk);
		end
		chk("frame_taken", {31'h0, frame_taken}, {31'h0, ok});
		chk("frame_dropped", {31'h0, frame_dropped}, {31'h0, ~ok});
		idle();
	endtask

	initial begin
		failures = 0;
		n_tests = 0;
		cyc = 0;
		div_ff = 4'h0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		chk("ref_count", 32'(ref_count), 32'(REF_REG_RST));
		chk("fb_count", 32'(fb_count), {16'h0, FB_LO_RST});
		chk("post_div", 32'(post_div), 32'(PDIV_1));
		rdchk("stat", OFS_STAT, 32'h0);
		rdchk("half", OFS_HALF, 32'(HALF_RST));
		rdchk("unmapped", 8'h0C, 32'h0);
		apb(1'b1, OFS_HALF, 32'h3);
		rdchk("half", OFS_HALF, 32'h3);
		$display("test reset done");
		// Host picks ratio and comparison rate
		for (int i = 0; i < 4; i++) begin
			frame(RA_REF, {3'h0, 2'(i), 11'h060}, 1'b1);
			chk("post_div", 32'(post_div), 32'(i));
			chk("ref_count", 32'(ref_count), 32'h60);
		end
		frame(RA_FB_LO, 16'h1194, 1'b1);
		// Upper bits beyond the count are dropped
		frame(RA_FB_HI, 16'hFFFF, 1'b1);
		chk("fb_count", 32'(fb_count), 32'h31194);
		$display("test dividers done");
		frame(5'h03, 16'h0000, 1'b0);
		frame(5'h1F, 16'h0000, 1'b0);
		chk("ref_count", 32'(ref_count), 32'h60);
		chk("fb_count", 32'(fb_count), 32'h31194);
		chk("post_div", 32'(post_div), 32'(PDIV_8));
		$display("test unknown address done");
		apb(1'b1, OFS_FRAME, {11'h000, RA_REF, 16'h0000});
		rdchk("stat", OFS_STAT, 32'h4);
		apb(1'b1, OFS_STAT, 32'h4);
		rdchk("stat", OFS_STAT, 32'h0);
		apb(1'b1, OFS_FRAME, {11'h000, RA_REF, 16'h0005});
		apb(1'b1, OFS_FRAME, {11'h000, RA_REF, 16'h0007});
		idle();
		chk("stat", rd, 32'h2);
		rdchk("frame", OFS_FRAME, {11'h000, RA_REF, 16'h0005});
		repeat (8) @(posedge pclk);
		chk("ref_count", 32'(ref_count), 32'h5);
		apb(1'b1, OFS_STAT, 32'h2);
		rdchk("stat", OFS_STAT, 32'h0);
		$display("test refusals done");
		frame(RA_FB_HI, 16'h0000, 1'b1);
		frame(RA_FB_LO, 16'h0004, 1'b1);
		frame(RA_REF, 16'h1003, 1'b1);
		chk("post_div", 32'(post_div), 32'(PDIV_4));
		per(0, 3 * REF_T, "comp_tick");
		per(1, 4 * VCO_T, "fb_tick");
		per(2, 4 * VCO_T, "lo_out");
		$display("test loop done");
		end_sim();
	end
endmodule
